// ---- logic/rtc_alarm_pkg.sv ----
/*
 * Shared constants and types for the clock/calendar register and alarm block.
 * Assumes a 32-bit APB master and a timekeeping core that supplies BCD time.
 */
`default_nettype none
package rtc_alarm_pkg;
    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFF_CLOCK_CFG  = 8'h00;
    localparam logic [7:0] OFF_VALUE_WIN  = 8'h04;
    localparam logic [7:0] OFF_ALARM_CFG  = 8'h08;
    localparam logic [7:0] OFF_ALARM_WIN  = 8'h0C;
    localparam logic [7:0] OFF_UNLOCK_KEY = 8'h10;
    localparam logic [7:0] OFF_POWER_CTRL = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h1C;
    // =====================================================================
    // field positions
    localparam int BIT_WREN      = 13;
    localparam int BIT_PTR_LO    = 8;
    localparam int BIT_ENABLE    = 15;
    localparam int BIT_CHIME     = 14;
    localparam int BIT_MASK_LO   = 10;
    localparam int BIT_CLKSEL_LO = 10;
    localparam int BIT_IRQ_ALARM = 0;
    // =====================================================================
    // values
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;
    localparam logic [7:0]  REPEAT_MAX   = 8'hFF;
    localparam logic [7:0]  REPEAT_ZERO  = 8'h00;
    localparam logic [15:0] ALARM_CFG_RST = 16'h0000;
    localparam logic [1:0]  PTR_MIN_SEC  = 2'b00;
    localparam logic [1:0]  PTR_WD_HOUR  = 2'b01;
    localparam logic [1:0]  PTR_MON_DAY  = 2'b10;
    localparam logic [1:0]  PTR_TOP      = 2'b11;
    localparam logic [3:0]  MASK_HALF_SEC = 4'h0;
    localparam logic [3:0]  MASK_SEC      = 4'h1;
    localparam logic [3:0]  MASK_TEN_SEC  = 4'h2;
    localparam logic [3:0]  MASK_MINUTE   = 4'h3;
    localparam logic [3:0]  MASK_TEN_MIN  = 4'h4;
    localparam logic [3:0]  MASK_HOUR     = 4'h5;
    localparam logic [3:0]  MASK_DAY      = 4'h6;
    localparam logic [3:0]  MASK_WEEK     = 4'h7;
    localparam logic [3:0]  MASK_MONTH    = 4'h8;
    localparam logic [3:0]  MASK_YEAR     = 4'h9;
    localparam int IRQ_W = 1;
    // =====================================================================
    // types
    typedef enum logic [1:0] {
        CLK_SECONDARY_OSC = 2'b00,
        CLK_LOW_POWER_RC  = 2'b01,
        CLK_EXT_50HZ      = 2'b10,
        CLK_EXT_60HZ      = 2'b11
    } ref_clk_t;
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_OPEN = 2'b10
    } key_state_t;
    typedef struct packed {
        logic       halfSec;
        logic [6:0] second;
        logic [6:0] minute;
        logic [5:0] hour;
        logic [2:0] weekday;
        logic [5:0] day;
        logic [4:0] month;
        logic [7:0] year;
    } time_t;
    typedef struct packed {
        logic        valid;
        logic [1:0]  sel;
        logic        hiEn;
        logic        loEn;
        logic [15:0] data;
    } timer_wr_t;
endpackage
`default_nettype wire

// ---- logic/rtc_alarm_register_access.sv ----
/*
 * Register window, write lock, alarm configuration and alarm matching of the
 * clock/calendar, reached over APB. Assumes curTime and halfSecTick come from
 * the timekeeping core on clk_sys; timer writes are handed to that core.
 */
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - value window pointer picks min/sec, weekday/hour, month/day or year pair
// - alarm window pointer picks alarm min/sec, weekday/hour, month/day, power times
// - writing alarm window high byte decrements pointer, holding at 00
// - any read of either window decrements its pointer, byte or word alike
// - timer writes only pass while the write-enable bit is set
// - write-enable may be set only right after the 55h, AAh key pair
// - two-bit field selects secondary osc, low-power RC, 50 Hz or 60 Hz
// - alarm enable clears after an event with repeat zero and chime off
// - chime on lets repeat count wrap 00h to FFh, else stops at 00h
// - four-bit mask sets interval half second to year; codes above reserved
// - repeat count decrements on every alarm event while above 00h
// - alarm month/day holds BCD month tens, month ones, day tens, day ones
// - alarm weekday/hour holds BCD weekday, hour tens, hour ones
// - writes to alarm month/day and weekday/hour need write-enable set
// - all alarm configuration bits reset to zero
module rtc_alarm_register_access
    import rtc_alarm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // timekeeping core
    input  wire time_t             curTime,
    input  wire logic              halfSecTick,
    output timer_wr_t              timerWr,
    output ref_clk_t               refClkSel,
    // events
    output logic                   alarmEvent,
    output logic                   irq
);
    // =====================================================================
    // bus decode
    logic [7:0]   addrByte;
    logic         setup;
    logic         access;
    logic         wrAcc;
    logic         rdAcc;
    logic         mapped;
    logic         hiWr;
    logic         loWr;
    assign addrByte = paddr[7:0];
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign wrAcc    = access && pwrite && mapped;
    assign rdAcc    = access && !pwrite && mapped;
    assign hiWr     = pstrb[1];
    assign loWr     = pstrb[0];

    always_comb begin
        unique case (addrByte)
            OFF_CLOCK_CFG, OFF_VALUE_WIN, OFF_ALARM_CFG, OFF_ALARM_WIN,
            OFF_UNLOCK_KEY, OFF_POWER_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // read data is captured in the setup cycle, so no wait state is needed
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    // =====================================================================
    // registers
    logic             wren_reg;
    logic [1:0]       valPtr_reg;
    logic             almEnable_reg;
    logic             chime_reg;
    logic [3:0]       almMask_reg;
    logic [1:0]       almPtr_reg;
    logic [7:0]       repeat_reg;
    logic [6:0]       almSec_reg;
    logic [6:0]       almMin_reg;
    logic [5:0]       almHour_reg;
    logic [2:0]       almWday_reg;
    logic [5:0]       almDay_reg;
    logic [4:0]       almMonth_reg;
    logic [7:0]       pwrStab_reg;
    logic [7:0]       pwrSamp_reg;
    ref_clk_t         clkSel_reg;
    logic [IRQ_W-1:0] irqStatus_reg;
    logic [IRQ_W-1:0] irqMask_reg;
    key_state_t       keyState_reg;
    logic [31:0]      prdata_reg;
    timer_wr_t        timerWr_reg;
    // =====================================================================
    // window views
    logic [15:0] valueView;
    logic [15:0] alarmView;
    always_comb begin
        unique case (valPtr_reg)
            PTR_MIN_SEC: valueView = {1'b0, curTime.minute, 1'b0, curTime.second};
            PTR_WD_HOUR: valueView = {5'h00, curTime.weekday, 2'b00, curTime.hour};
            PTR_MON_DAY: valueView = {3'b000, curTime.month, 2'b00, curTime.day};
            PTR_TOP:     valueView = {8'h00, curTime.year};
        endcase
    end
    always_comb begin
        unique case (almPtr_reg)
            PTR_MIN_SEC: alarmView = {1'b0, almMin_reg, 1'b0, almSec_reg};
            PTR_WD_HOUR: alarmView = {5'h00, almWday_reg, 2'b00, almHour_reg};
            PTR_MON_DAY: alarmView = {3'b000, almMonth_reg, 2'b00, almDay_reg};
            PTR_TOP:     alarmView = {pwrStab_reg, pwrSamp_reg};
        endcase
    end
    logic [31:0] readMux;
    always_comb begin
        readMux = 32'h0000_0000;
        unique case (addrByte)
            OFF_CLOCK_CFG: begin
                readMux[BIT_WREN] = wren_reg;
                readMux[BIT_PTR_LO +: 2] = valPtr_reg;
            end
            OFF_VALUE_WIN:  readMux[15:0] = valueView;
            OFF_ALARM_CFG:  readMux[15:0] = {almEnable_reg, chime_reg, almMask_reg,
                                             almPtr_reg, repeat_reg};
            OFF_ALARM_WIN:  readMux[15:0] = alarmView;
            OFF_POWER_CTRL: readMux[BIT_CLKSEL_LO +: 2] = clkSel_reg;
            OFF_IRQ_STATUS: readMux[IRQ_W-1:0] = irqStatus_reg;
            OFF_IRQ_MASK:   readMux[IRQ_W-1:0] = irqMask_reg;
            default:        readMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= readMux;
        end
    end
    assign prdata = prdata_reg;
    // =====================================================================
    // unlock key sequence
    logic keyWr;
    assign keyWr = wrAcc && (addrByte == OFF_UNLOCK_KEY) && loWr;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            keyState_reg <= KEY_IDLE;
        end else if (access) begin
            // the open window lasts for exactly the next bus transfer
            unique case (keyState_reg)
                KEY_IDLE: keyState_reg <= (keyWr && pwdata[7:0] == KEY_FIRST)
                                          ? KEY_GOT1 : KEY_IDLE;
                KEY_GOT1: keyState_reg <= (keyWr && pwdata[7:0] == KEY_SECOND)
                                          ? KEY_OPEN : KEY_IDLE;
                KEY_OPEN: keyState_reg <= KEY_IDLE;
                default:  keyState_reg <= KEY_IDLE;
            endcase
        end
    end

    // =====================================================================
    // clock configuration and value window pointer
    logic cfgWr;
    logic valWinRd;
    logic valWinHiWr;
    assign cfgWr      = wrAcc && (addrByte == OFF_CLOCK_CFG);
    assign valWinRd   = rdAcc && (addrByte == OFF_VALUE_WIN);
    assign valWinHiWr = wrAcc && (addrByte == OFF_VALUE_WIN) && hiWr;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wren_reg <= 1'b0;
        end else if (cfgWr && pstrb[1]) begin
            // clearing is always allowed; setting only inside the key window
            wren_reg <= pwdata[BIT_WREN] && (wren_reg || keyState_reg == KEY_OPEN);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            valPtr_reg <= PTR_MIN_SEC;
        end else if (cfgWr && pstrb[1]) begin
            valPtr_reg <= pwdata[BIT_PTR_LO +: 2];
        end else if ((valWinRd || valWinHiWr) && valPtr_reg != PTR_MIN_SEC) begin
            valPtr_reg <= valPtr_reg - 2'b01;
        end
    end
    // timer writes go to the core only while unlocked
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timerWr_reg <= '0;
        end else begin
            timerWr_reg.valid <= wrAcc && (addrByte == OFF_VALUE_WIN) && wren_reg
                                 && (hiWr || loWr);
            timerWr_reg.sel   <= valPtr_reg;
            timerWr_reg.hiEn  <= hiWr;
            timerWr_reg.loEn  <= loWr;
            timerWr_reg.data  <= pwdata[15:0];
        end
    end
    assign timerWr = timerWr_reg;
    // =====================================================================
    // reference clock select
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clkSel_reg <= CLK_SECONDARY_OSC;
        end else if (wrAcc && addrByte == OFF_POWER_CTRL && pstrb[1]) begin
            clkSel_reg <= ref_clk_t'(pwdata[BIT_CLKSEL_LO +: 2]);
        end
    end
    assign refClkSel = clkSel_reg;
    // =====================================================================
    // alarm matching
    logic [6:0] matchChain;
    logic       maskMatch;
    assign matchChain[0] = !curTime.halfSec;
    assign matchChain[1] = matchChain[0] && curTime.second[3:0] == almSec_reg[3:0];
    assign matchChain[2] = matchChain[1] && curTime.second[6:4] == almSec_reg[6:4];
    assign matchChain[3] = matchChain[2] && curTime.minute[3:0] == almMin_reg[3:0];
    assign matchChain[4] = matchChain[3] && curTime.minute[6:4] == almMin_reg[6:4];
    assign matchChain[5] = matchChain[4] && curTime.hour == almHour_reg;
    assign matchChain[6] = matchChain[5] && curTime.day == almDay_reg;

    always_comb begin
        unique case (almMask_reg)
            MASK_HALF_SEC: maskMatch = 1'b1;
            MASK_SEC:      maskMatch = matchChain[0];
            MASK_TEN_SEC:  maskMatch = matchChain[1];
            MASK_MINUTE:   maskMatch = matchChain[2];
            MASK_TEN_MIN:  maskMatch = matchChain[3];
            MASK_HOUR:     maskMatch = matchChain[4];
            MASK_DAY:      maskMatch = matchChain[5];
            MASK_WEEK:     maskMatch = matchChain[5] && curTime.weekday == almWday_reg;
            MASK_MONTH:    maskMatch = matchChain[6];
            MASK_YEAR:     maskMatch = matchChain[6] && curTime.month == almMonth_reg;
            default:       maskMatch = 1'b0; // reserved codes never fire
        endcase
    end
    assign alarmEvent = almEnable_reg && halfSecTick && maskMatch;
    // =====================================================================
    // alarm configuration and repeat counter
    logic almCfgWr;
    logic almWinRd;
    logic almWinHiWr;
    logic almWinLoWr;
    assign almCfgWr   = wrAcc && (addrByte == OFF_ALARM_CFG);
    assign almWinRd   = rdAcc && (addrByte == OFF_ALARM_WIN);
    assign almWinHiWr = wrAcc && (addrByte == OFF_ALARM_WIN) && hiWr;
    assign almWinLoWr = wrAcc && (addrByte == OFF_ALARM_WIN) && loWr;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {almEnable_reg, chime_reg, almMask_reg, almPtr_reg} <= ALARM_CFG_RST[15:8];
        end else begin
            if (almCfgWr && pstrb[1]) begin
                {almEnable_reg, chime_reg, almMask_reg, almPtr_reg} <= pwdata[15:8];
            end else begin
                if (alarmEvent && repeat_reg == REPEAT_ZERO && !chime_reg) begin
                    almEnable_reg <= 1'b0;
                end
                if ((almWinRd || almWinHiWr) && almPtr_reg != PTR_MIN_SEC) begin
                    almPtr_reg <= almPtr_reg - 2'b01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            repeat_reg <= ALARM_CFG_RST[7:0];
        end else if (almCfgWr && pstrb[0]) begin
            repeat_reg <= pwdata[7:0];
        end else if (alarmEvent) begin
            if (repeat_reg != REPEAT_ZERO) begin
                repeat_reg <= repeat_reg - 8'h01;
            end else if (chime_reg) begin
                repeat_reg <= REPEAT_MAX;
            end
        end
    end

    // =====================================================================
    // alarm value registers behind the alarm window
    logic almValOk;
    assign almValOk = wren_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {almMin_reg, almSec_reg} <= 14'h0000;
            {almWday_reg, almHour_reg, almMonth_reg, almDay_reg} <= 20'h0_0000;
            {pwrStab_reg, pwrSamp_reg} <= 16'h0000;
        end else begin
            unique case (almPtr_reg)
                PTR_MIN_SEC: begin
                    if (almWinHiWr && almValOk) almMin_reg <= pwdata[14:8];
                    if (almWinLoWr && almValOk) almSec_reg <= pwdata[6:0];
                end
                PTR_WD_HOUR: begin
                    if (almWinHiWr && almValOk) almWday_reg <= pwdata[10:8];
                    if (almWinLoWr && almValOk) almHour_reg <= pwdata[5:0];
                end
                PTR_MON_DAY: begin
                    if (almWinHiWr && almValOk) almMonth_reg <= pwdata[12:8];
                    if (almWinLoWr && almValOk) almDay_reg <= pwdata[5:0];
                end
                PTR_TOP: begin
                    if (almWinHiWr) pwrStab_reg <= pwdata[15:8];
                    if (almWinLoWr) pwrSamp_reg <= pwdata[7:0];
                end
            endcase
        end
    end

    // =====================================================================
    // interrupt status and mask; a new event wins over a clearing write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqStatus_reg <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (i == BIT_IRQ_ALARM && alarmEvent) begin
                    irqStatus_reg[i] <= 1'b1;
                end else if (wrAcc && addrByte == OFF_IRQ_STATUS && pstrb[0] && pwdata[i]) begin
                    irqStatus_reg[i] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqMask_reg <= '0;
        end else if (wrAcc && addrByte == OFF_IRQ_MASK && pstrb[0]) begin
            irqMask_reg <= pwdata[IRQ_W-1:0];
        end
    end
    assign irq = |(irqStatus_reg & irqMask_reg);
    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_ptr_floor;
        almWinHiWr && almPtr_reg == PTR_MIN_SEC |=> almPtr_reg == PTR_MIN_SEC;
    endproperty
    a_ptr_floor: assert property (p_ptr_floor) else $error("alarm pointer left 00");
    property p_val_ptr_dec;
        valWinRd && !cfgWr && valPtr_reg != PTR_MIN_SEC
            |=> valPtr_reg == $past(valPtr_reg) - 2'b01;
    endproperty
    a_val_ptr_dec: assert property (p_val_ptr_dec) else $error("value pointer stuck");
    property p_wren_gate;
        timerWr.valid |-> $past(wren_reg);
    endproperty
    a_wren_gate: assert property (p_wren_gate) else $error("timer write while locked");
    property p_unlock;
        $rose(wren_reg) |-> $past(keyState_reg) == KEY_OPEN;
    endproperty
    a_unlock: assert property (p_unlock) else $error("write enable set without key");
    property p_self_clear;
        alarmEvent && repeat_reg == REPEAT_ZERO && !chime_reg && !almCfgWr |=> !almEnable_reg;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("alarm enable not cleared");
    property p_wrap;
        alarmEvent && repeat_reg == REPEAT_ZERO && chime_reg && !almCfgWr
            |=> repeat_reg == REPEAT_MAX;
    endproperty
    a_wrap: assert property (p_wrap) else $error("repeat count did not wrap");
    property p_repeat_dec;
        alarmEvent && repeat_reg != REPEAT_ZERO && !almCfgWr
            |=> repeat_reg == $past(repeat_reg) - 8'h01;
    endproperty
    a_repeat_dec: assert property (p_repeat_dec) else $error("repeat count not decremented");
    property p_md_locked;
        almWinHiWr && almPtr_reg == PTR_MON_DAY && !wren_reg |=> $stable(almMonth_reg);
    endproperty
    a_md_locked: assert property (p_md_locked) else $error("month changed while locked");
    property p_reserved;
        almMask_reg > MASK_YEAR |-> !alarmEvent;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mask fired");
    // software may clear the status right after, so only the next cycle is owed
    property p_event_irq;
        alarmEvent && irqMask_reg[BIT_IRQ_ALARM] && !(wrAcc && addrByte == OFF_IRQ_MASK)
            |=> irq;
    endproperty
    a_event_irq: assert property (p_event_irq) else $error("alarm did not raise irq");
    c_unlock_set: cover property ($rose(wren_reg));
    c_chime_wrap: cover property (alarmEvent && repeat_reg == REPEAT_ZERO && chime_reg);
    c_auto_off:   cover property ($fell(almEnable_reg) && !$past(almCfgWr));
    c_ptr_walk:   cover property (almWinRd && almPtr_reg == PTR_TOP
                                  ##[1:20] almPtr_reg == PTR_MIN_SEC);
endmodule
`default_nettype wire

// ---- bench/rtc_alarm_register_access_bench.sv ----
/*
 * Self-checking bench for the clock/calendar register and alarm block.
 * Assumes the APB slave answers with pready; the bench drives time directly.
 */
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_register_access_bench;
    import rtc_alarm_pkg::*;
    logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, halfSecTick, alarmEvent, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0]  pstrb;
    time_t       curTime;
    timer_wr_t   timerWr;
    ref_clk_t    refClkSel;
    logic [31:0] expQ[$];
    int          errors, total_checks;
    rtc_alarm_register_access rtc_alarm_register_access_i (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .curTime(curTime), .halfSecTick(halfSecTick), .timerWr(timerWr),
        .refClkSel(refClkSel), .alarmEvent(alarmEvent), .irq(irq));
    // ==========================================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        if (expQ.size() != 0) errors++;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // setup then access, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0000_0000, 4'h3);
    endtask
    task automatic tick(input logic e);
        @(posedge clk_sys);
        halfSecTick <= 1'b1;
        #1 chk("alarmEvent", {31'h0, e}, {31'h0, alarmEvent});
        @(posedge clk_sys);
        halfSecTick <= 1'b0;
    endtask
    // ==========================================================================
    // watcher: each completed access checks pslverr; each read is compared with the oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && pready) begin
            chk("pslverr", {31'h0, paddr > OFF_IRQ_MASK}, {31'h0, pslverr});
            if (!pwrite && expQ.size() > 0) chk("prdata", expQ.pop_front(), prdata);
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ==========================================================================
    // main sequence
    initial begin
        errors = 0; total_checks = 0; rnd = 32'ha763;
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; pstrb = 4'h0; halfSecTick = 1'b0; curTime = '0;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        rd(OFF_ALARM_CFG, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        wr(OFF_CLOCK_CFG, 32'h0000_2000);
        rd(OFF_CLOCK_CFG, 32'h0000_0000);
        wr(OFF_UNLOCK_KEY, {24'h0, KEY_FIRST});
        wr(OFF_UNLOCK_KEY, {24'h0, KEY_SECOND});
        wr(OFF_CLOCK_CFG, 32'h0000_2300);
        rd(OFF_CLOCK_CFG, 32'h0000_2300);
        $display("unlock test done");
        for (int p = 3; p >= 0; p--) begin
            rnd = lfsr(rnd);
            curTime <= time_t'({rnd[26:0], rnd[15:0]});
            @(posedge clk_sys);
            case (p)
                3: rd(OFF_VALUE_WIN, {24'h0, curTime.year});
                2: rd(OFF_VALUE_WIN, {19'h0, curTime.month, 2'h0, curTime.day});
                1: rd(OFF_VALUE_WIN, {21'h0, curTime.weekday, 2'h0, curTime.hour});
                default: rd(OFF_VALUE_WIN, {17'h0, curTime.minute, 1'b0, curTime.second});
            endcase
        end
        rd(OFF_CLOCK_CFG, 32'h0000_2000);
        wr(OFF_VALUE_WIN, 32'h0000_1234);
        #1 chk("timerWr", {11'h0, 1'b1, PTR_MIN_SEC, 2'b11, 16'h1234}, {11'h0, timerWr});
        $display("value window test done");
        wr(OFF_ALARM_CFG, 32'h0000_0300);
        wr(OFF_ALARM_WIN, 32'h0000_1234);
        wr(OFF_ALARM_WIN, 32'h0000_FFFF);
        wr(OFF_ALARM_WIN, 32'h0000_FFFF);
        rd(OFF_ALARM_CFG, 32'h0000_0000);
        wr(OFF_ALARM_CFG, 32'h0000_0300);
        rd(OFF_ALARM_WIN, 32'h0000_1234);
        rd(OFF_ALARM_WIN, 32'h0000_1F3F);
        rd(OFF_ALARM_WIN, 32'h0000_073F);
        wr(OFF_CLOCK_CFG, 32'h0000_0000);
        wr(OFF_VALUE_WIN, 32'h0000_5678);
        #1 chk("timerWr.valid", 32'h0, {31'h0, timerWr.valid});
        wr(OFF_ALARM_CFG, 32'h0000_0200);
        wr(OFF_ALARM_WIN, 32'h0000_0000);
        wr(OFF_ALARM_CFG, 32'h0000_0200);
        rd(OFF_ALARM_WIN, 32'h0000_1F3F);
        $display("alarm window test done");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_POWER_CTRL, 32'(i) << BIT_CLKSEL_LO);
            #1 chk("refClkSel", 32'(i), {30'h0, refClkSel});
        end
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        wr(OFF_ALARM_CFG, 32'h0000_8001);
        tick(1'b1);
        rd(OFF_ALARM_CFG, 32'h0000_8000);
        tick(1'b1);
        rd(OFF_ALARM_CFG, 32'h0000_0000);
        tick(1'b0);
        rd(OFF_IRQ_STATUS, 32'h0000_0001);
        #1 chk("irq", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(OFF_ALARM_CFG, 32'h0000_C000);
        tick(1'b1);
        rd(OFF_ALARM_CFG, 32'h0000_C0FF);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(OFF_ALARM_CFG, 32'h0000_8400);
        curTime.halfSec <= 1'b1;
        tick(1'b0);
        curTime.halfSec <= 1'b0;
        tick(1'b1);
        wr(OFF_ALARM_CFG, 32'h0000_8800);
        curTime.second <= 7'h05;
        tick(1'b0);
        curTime.second <= 7'h10;
        tick(1'b1);
        wr(OFF_ALARM_CFG, 32'h0000_A800);
        tick(1'b0);
        $display("alarm test done");
        repeat (2) @(posedge clk_sys);
        final_report();
    end
endmodule
`default_nettype wire
